// file: rtl/tsf_cond_map.sv
`timescale 1ns/1ps
module tsf_cond_map import tsf_pkg::*; (
  input wire logic inv_volts,
  input wire logic inv_amps,
  input wire logic inv_temp,
  input wire logic inv_hum,
  input wire logic inv_ohms,
  input wire logic inv_coul,
  input wire logic seq_abort,
  input wire logic caution,
  input wire logic adj_sum,
  input wire logic cal_start,
  input wire logic trig_wait,
  input wire logic arm_wait,
  input wire logic calc_busy,
  input wire logic idle_in,
  input wire logic seq_run,
  input wire logic layer_one,
  input wire logic layer_two,
  output logic [NGRP-1:0][DW-1:0] cond
);
  always_comb begin
    cond = '0;
    cond[G_QUES][QB_VOLT] = inv_volts;
    cond[G_QUES][QB_AMP] = inv_amps;
    cond[G_QUES][QB_TEMP] = inv_temp;
    cond[G_QUES][QB_HUM] = inv_hum;
    cond[G_QUES][QB_OHM] = inv_ohms;
    cond[G_QUES][QB_COUL] = inv_coul;
    cond[G_QUES][QB_SEQ] = seq_abort;
    cond[G_QUES][QB_CAUT] = caution;
    cond[G_QUES][QB_ADJ] = adj_sum;
    cond[G_OPER][OB_CAL] = cal_start;
    cond[G_OPER][OB_TRIG] = trig_wait;
    cond[G_OPER][OB_ARM] = arm_wait;
    cond[G_OPER][OB_CALC] = calc_busy;
    cond[G_OPER][OB_IDLE] = idle_in;
    cond[G_OPER][OB_SEQ] = seq_run;
    cond[G_TRIG][TB_WAIT] = trig_wait;
    cond[G_ARM][AB_WAIT] = arm_wait;
    cond[G_SEQ][SB_GATE1] = layer_one;
    cond[G_SEQ][SB_GATE2] = layer_two;
  end
endmodule : tsf_cond_map

// file: rtl/tsf_edge_filter.sv
`timescale 1ns/1ps
module tsf_edge_filter import tsf_pkg::*; #(
  parameter logic [DW-1:0] MASK = '1
) (
  input wire logic clk,
  input wire logic rst,
  tsf_grp_if.filt g
);
  typedef struct packed {
    logic [DW-1:0] prev;
    logic [DW-1:0] rise;
    logic [DW-1:0] fall;
    logic [DW-1:0] evt;
  } tsf_flt_t;
  tsf_flt_t s_q;
  tsf_flt_t s_d;
  logic [DW-1:0] cur;
  logic [DW-1:0] rise_hit;
  logic [DW-1:0] fall_hit;

  always_comb begin
    cur = g.cond & MASK;
    rise_hit = s_q.rise & cur & ~s_q.prev;
    fall_hit = s_q.fall & ~cur & s_q.prev;
    s_d = s_q;
    s_d.prev = cur;
    if (g.wr_rise) begin
      s_d.rise = g.wdata & MASK;
    end
    if (g.wr_fall) begin
      s_d.fall = g.wdata & MASK;
    end
    s_d.evt = (s_q.evt & ~{DW{g.clr}}) | rise_hit | fall_hit;
    // prev loads the live level so a condition already high at reset is no edge
    if (rst) begin
      s_d.rise = RISE_RST & MASK;
      s_d.fall = FALL_RST & MASK;
      s_d.evt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign g.rise = s_q.rise;
  assign g.fall = s_q.fall;
  assign g.evt = s_q.evt;

  chk_rise_sets_evt: assert property (@(posedge clk) disable iff (rst)
    (rise_hit != '0) |=> ((g.evt & $past(rise_hit)) == $past(rise_hit)))
    else $error("enabled rising edge did not set event");
  chk_fall_sets_evt: assert property (@(posedge clk) disable iff (rst)
    (fall_hit != '0) |=> ((g.evt & $past(fall_hit)) == $past(fall_hit)))
    else $error("enabled falling edge did not set event");
  chk_evt_holds: assert property (@(posedge clk) disable iff (rst)
    !g.clr |=> ((g.evt & $past(g.evt)) == $past(g.evt)))
    else $error("event bit dropped without clear");
  chk_unused_zero: assert property (@(posedge clk) disable iff (rst)
    ((g.rise | g.fall | g.evt) & ~MASK) == '0)
    else $error("unused filter or event bit is set");
endmodule : tsf_edge_filter

// file: rtl/tsf_top.sv
`timescale 1ns/1ps
module tsf_top import tsf_pkg::*; (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic INVALID_VOLTS,
  input wire logic INVALID_AMPS,
  input wire logic INVALID_TEMP,
  input wire logic INVALID_HUMIDITY,
  input wire logic INVALID_OHMS,
  input wire logic INVALID_COULOMBS,
  input wire logic SEQ_TEST_ABORTED,
  input wire logic COMMAND_CAUTION,
  input wire logic ADJUST_PROC_SUMMARY,
  input wire logic CAL_START,
  input wire logic TRIG_LAYER_WAIT,
  input wire logic ARM_LAYER_WAIT,
  input wire logic READING_COMPUTE_BUSY,
  input wire logic IDLE_ENTERED,
  input wire logic SEQ_TEST_RUNNING,
  input wire logic ARM_LAYER_ONE,
  input wire logic ARM_LAYER_TWO,
  input wire logic CMD_WR,
  input wire logic [SW-1:0] CMD_SEL,
  input wire logic [DW-1:0] CMD_DATA,
  input wire logic [SW-1:0] QRY_SEL,
  output logic [DW-1:0] QRY_DATA,
  input wire logic EVT_RD,
  input wire logic [GW-1:0] EVT_SEL,
  output logic [DW-1:0] EVT_DATA,
  input wire logic EVT_CLR_ALL,
  output logic [NGRP-1:0] EVT_PENDING,
  output logic SEL_ERROR
);
  typedef struct packed {
    logic [DW-1:0] qry;
    logic [DW-1:0] evt_rd;
    logic sel_err;
  } tsf_top_t;
  tsf_top_t s_q;
  tsf_top_t s_d;

  logic [NGRP-1:0][DW-1:0] cond_all;
  logic [NGRP-1:0][DW-1:0] rise_all;
  logic [NGRP-1:0][DW-1:0] fall_all;
  logic [NGRP-1:0][DW-1:0] evt_all;
  logic [DW-1:0] evt_sel_now;
  logic evt_sel_ok;

  // the command and query ports share one select map; out-of-range codes write nothing, raise SEL_ERROR on a write and read back zero
  function automatic logic sel_ok(input logic [SW-1:0] s);
    return s < SEL_NREG;
  endfunction : sel_ok

  function automatic logic [GW-1:0] sel_grp(input logic [SW-1:0] s);
    return s[SW-1:1];
  endfunction : sel_grp

  tsf_cond_map u_map (
    .inv_volts(INVALID_VOLTS),
    .inv_amps(INVALID_AMPS),
    .inv_temp(INVALID_TEMP),
    .inv_hum(INVALID_HUMIDITY),
    .inv_ohms(INVALID_OHMS),
    .inv_coul(INVALID_COULOMBS),
    .seq_abort(SEQ_TEST_ABORTED),
    .caution(COMMAND_CAUTION),
    .adj_sum(ADJUST_PROC_SUMMARY),
    .cal_start(CAL_START),
    .trig_wait(TRIG_LAYER_WAIT),
    .arm_wait(ARM_LAYER_WAIT),
    .calc_busy(READING_COMPUTE_BUSY),
    .idle_in(IDLE_ENTERED),
    .seq_run(SEQ_TEST_RUNNING),
    .layer_one(ARM_LAYER_ONE),
    .layer_two(ARM_LAYER_TWO),
    .cond(cond_all)
  );

  for (genvar gi = 0; gi < NGRP; gi++) begin : g_grp
    tsf_grp_if grp ();
    assign grp.cond = cond_all[gi];
    assign grp.wdata = CMD_DATA;
    assign grp.wr_rise = CMD_WR && sel_ok(CMD_SEL) && sel_grp(CMD_SEL) == GW'(gi) && !CMD_SEL[SEL_FALL_BIT];
    assign grp.wr_fall = CMD_WR && sel_ok(CMD_SEL) && sel_grp(CMD_SEL) == GW'(gi) && CMD_SEL[SEL_FALL_BIT];
    assign grp.clr = EVT_CLR_ALL || (EVT_RD && EVT_SEL == GW'(gi));
    assign rise_all[gi] = grp.rise;
    assign fall_all[gi] = grp.fall;
    assign evt_all[gi] = grp.evt;
    assign EVT_PENDING[gi] = |grp.evt;
    tsf_edge_filter #(
      .MASK(USED_MASK[gi])
    ) u_flt (
      .clk(CLK),
      .rst(RESET),
      .g(grp)
    );
  end

  always_comb begin
    evt_sel_ok = EVT_SEL < GW'(NGRP);
    evt_sel_now = evt_sel_ok ? evt_all[EVT_SEL] : '0;
    s_d = s_q;
    if (sel_ok(QRY_SEL)) begin
      s_d.qry = QRY_SEL[SEL_FALL_BIT] ? fall_all[sel_grp(QRY_SEL)] : rise_all[sel_grp(QRY_SEL)];
    end else begin
      s_d.qry = '0;
    end
    // snapshot taken before the clear lands; a set in the same cycle stays pending
    if (EVT_RD) begin
      s_d.evt_rd = evt_sel_now;
    end
    s_d.sel_err = (CMD_WR && !sel_ok(CMD_SEL)) || (EVT_RD && !evt_sel_ok);
    if (RESET) begin
      s_d = '0;
    end
  end

  always_ff @(posedge CLK) begin
    s_q <= s_d;
  end

  assign QRY_DATA = s_q.qry;
  assign EVT_DATA = s_q.evt_rd;
  assign SEL_ERROR = s_q.sel_err;

  chk_volt_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(INVALID_VOLTS) && rise_all[G_QUES][QB_VOLT]) |=> evt_all[G_QUES][QB_VOLT])
    else $error("volts invalid edge lost");
  chk_amp_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(INVALID_AMPS) && rise_all[G_QUES][QB_AMP]) |=> evt_all[G_QUES][QB_AMP])
    else $error("amps invalid edge lost");
  chk_temp_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(INVALID_TEMP) && rise_all[G_QUES][QB_TEMP]) |=> evt_all[G_QUES][QB_TEMP])
    else $error("temperature invalid edge lost");
  chk_hum_fall: assert property (@(posedge CLK) disable iff (RESET)
    ($fell(INVALID_HUMIDITY) && fall_all[G_QUES][QB_HUM]) |=> evt_all[G_QUES][QB_HUM])
    else $error("humidity valid-again edge lost");
  chk_ohm_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(INVALID_OHMS) && rise_all[G_QUES][QB_OHM]) |=> evt_all[G_QUES][QB_OHM])
    else $error("ohms invalid edge lost");
  chk_coul_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(INVALID_COULOMBS) && rise_all[G_QUES][QB_COUL]) |=> evt_all[G_QUES][QB_COUL])
    else $error("coulombs invalid edge lost");
  chk_abort_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(SEQ_TEST_ABORTED) && rise_all[G_QUES][QB_SEQ]) |=> evt_all[G_QUES][QB_SEQ])
    else $error("sequence abort edge lost");
  chk_caution_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(COMMAND_CAUTION) && rise_all[G_QUES][QB_CAUT]) |=> evt_all[G_QUES][QB_CAUT])
    else $error("command caution edge lost");
  chk_adjust_fall: assert property (@(posedge CLK) disable iff (RESET)
    ($fell(ADJUST_PROC_SUMMARY) && fall_all[G_QUES][QB_ADJ]) |=> evt_all[G_QUES][QB_ADJ])
    else $error("adjust summary fall edge lost");
  chk_cal_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(CAL_START) && rise_all[G_OPER][OB_CAL]) |=> evt_all[G_OPER][OB_CAL])
    else $error("calibration start edge lost");
  chk_trig_oper: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(TRIG_LAYER_WAIT) && rise_all[G_OPER][OB_TRIG]) |=> evt_all[G_OPER][OB_TRIG])
    else $error("trigger layer edge lost in operation group");
  chk_arm_oper: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(ARM_LAYER_WAIT) && rise_all[G_OPER][OB_ARM]) |=> evt_all[G_OPER][OB_ARM])
    else $error("arm layer edge lost in operation group");
  chk_calc_fall: assert property (@(posedge CLK) disable iff (RESET)
    ($fell(READING_COMPUTE_BUSY) && fall_all[G_OPER][OB_CALC]) |=> evt_all[G_OPER][OB_CALC])
    else $error("compute done edge lost");
  chk_idle_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(IDLE_ENTERED) && rise_all[G_OPER][OB_IDLE]) |=> evt_all[G_OPER][OB_IDLE])
    else $error("idle entry edge lost");
  chk_seqrun_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(SEQ_TEST_RUNNING) && rise_all[G_OPER][OB_SEQ]) |=> evt_all[G_OPER][OB_SEQ])
    else $error("sequence running edge lost");
  chk_trig_group: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(TRIG_LAYER_WAIT) && rise_all[G_TRIG][TB_WAIT]) |=> evt_all[G_TRIG][TB_WAIT])
    else $error("first layer wait edge lost");
  chk_arm_group: assert property (@(posedge CLK) disable iff (RESET)
    ($fell(ARM_LAYER_WAIT) && fall_all[G_ARM][AB_WAIT]) |=> evt_all[G_ARM][AB_WAIT])
    else $error("arm layer leave edge lost");
  chk_gate1_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(ARM_LAYER_ONE) && rise_all[G_SEQ][SB_GATE1]) |=> evt_all[G_SEQ][SB_GATE1])
    else $error("first gate level edge lost");
  chk_gate2_rise: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(ARM_LAYER_TWO) && rise_all[G_SEQ][SB_GATE2]) |=> evt_all[G_SEQ][SB_GATE2])
    else $error("second gate level edge lost");
  chk_rise_disabled: assert property (@(posedge CLK) disable iff (RESET)
    ($rose(IDLE_ENTERED) && !rise_all[G_OPER][OB_IDLE] && !evt_all[G_OPER][OB_IDLE])
    |=> !evt_all[G_OPER][OB_IDLE])
    else $error("disabled rise filter set an event");
  chk_fall_disabled: assert property (@(posedge CLK) disable iff (RESET)
    ($fell(INVALID_VOLTS) && !fall_all[G_QUES][QB_VOLT] && !evt_all[G_QUES][QB_VOLT])
    |=> !evt_all[G_QUES][QB_VOLT])
    else $error("disabled fall filter set an event");
  chk_write_rise: assert property (@(posedge CLK) disable iff (RESET)
    (CMD_WR && CMD_SEL == {G_QUES, 1'b0}) |=> rise_all[G_QUES] == ($past(CMD_DATA) & USED_MASK[G_QUES]))
    else $error("rise filter write not stored");
  chk_write_fall: assert property (@(posedge CLK) disable iff (RESET)
    (CMD_WR && CMD_SEL == {G_SEQ, 1'b1}) |=> fall_all[G_SEQ] == ($past(CMD_DATA) & USED_MASK[G_SEQ]))
    else $error("fall filter write not stored");
  chk_query_path: assert property (@(posedge CLK) disable iff (RESET)
    (QRY_SEL == {G_OPER, 1'b0} && !CMD_WR) |=> QRY_DATA == rise_all[G_OPER])
    else $error("query did not return the operation rise filter");
  chk_query_unmapped: assert property (@(posedge CLK) disable iff (RESET)
    !sel_ok(QRY_SEL) |=> QRY_DATA == '0)
    else $error("unmapped query returned data");
  chk_read_snap: assert property (@(posedge CLK) disable iff (RESET)
    (EVT_RD && EVT_SEL < GW'(NGRP)) |=> EVT_DATA == $past(evt_all[EVT_SEL]))
    else $error("event read did not return the snapshot");
  chk_read_clears: assert property (@(posedge CLK) disable iff (RESET)
    (EVT_RD && EVT_SEL == G_TRIG && !$rose(TRIG_LAYER_WAIT) && !$fell(TRIG_LAYER_WAIT))
    |=> evt_all[G_TRIG] == '0)
    else $error("event read left the trigger event set");
  chk_clear_all: assert property (@(posedge CLK) disable iff (RESET)
    (EVT_CLR_ALL && $stable(ARM_LAYER_ONE) && $stable(ARM_LAYER_TWO)) |=> evt_all[G_SEQ] == '0)
    else $error("clear all left a sequence event");
  chk_reset_state: assert property (@(posedge CLK)
    $past(RESET) |-> (rise_all[G_TRIG] == USED_MASK[G_TRIG] && fall_all[G_TRIG] == '0 && EVT_PENDING == '0))
    else $error("reset values wrong");
endmodule : tsf_top

// file: shared/tsf_grp_if.sv
`timescale 1ns/1ps
interface tsf_grp_if;
  import tsf_pkg::*;
  logic [DW-1:0] cond;
  logic [DW-1:0] wdata;
  logic wr_rise;
  logic wr_fall;
  logic clr;
  logic [DW-1:0] rise;
  logic [DW-1:0] fall;
  logic [DW-1:0] evt;
  modport filt (input cond, input wdata, input wr_rise, input wr_fall, input clr,
                output rise, output fall, output evt);
  modport ctrl (output cond, output wdata, output wr_rise, output wr_fall, output clr,
                input rise, input fall, input evt);
endinterface : tsf_grp_if

// file: shared/tsf_pkg.sv
// Notes on behaviour
// - invalid volts reading drives questionable condition bit 0.
// - invalid amps reading drives questionable condition bit 1.
// - invalid external temperature reading drives questionable condition bit 4.
// - invalid relative humidity reading drives questionable condition bit 9.
// - invalid ohms reading drives questionable condition bit 10.
// - invalid coulombs reading drives questionable condition bit 11.
// - aborted sequence test drives questionable condition bit 12.
// - questionable filters also hold command caution bit 14 and adjust summary bit 8.
// - start of calibration drives operation condition bit 0.
// - waiting in trigger layer drives operation condition bit 5.
// - waiting in an arm layer drives operation condition bit 6.
// - reading calculation in progress drives operation condition bit 9.
// - entering trigger model idle drives operation condition bit 10.
// - running sequence test drives operation condition bit 11.
// - trigger register uses only bit 1, first_layer_wait, set while in trigger layer.
// - arm register uses only bit 1, set while in an arm layer.
// - sequence bit 1, first_gate_level, follows arm layer one.
// - sequence bit 2, second_gate_level, follows arm layer two; other bits unused.
// - rise_filter bit one enables event on rising condition; zero disables it.
// - fall_filter bit one enables event on falling condition; zero disables it.
// - enabled falling edge of a condition bit sets its event bit.
package tsf_pkg;
  localparam int NGRP = 5;
  localparam int DW = 16;
  localparam int SW = 4;
  localparam int GW = 3;
  localparam logic [GW-1:0] G_QUES = 3'h0;
  localparam logic [GW-1:0] G_OPER = 3'h1;
  localparam logic [GW-1:0] G_TRIG = 3'h2;
  localparam logic [GW-1:0] G_ARM = 3'h3;
  localparam logic [GW-1:0] G_SEQ = 3'h4;
  localparam int QB_VOLT = 0;
  localparam int QB_AMP = 1;
  localparam int QB_TEMP = 4;
  localparam int QB_ADJ = 8;
  localparam int QB_HUM = 9;
  localparam int QB_OHM = 10;
  localparam int QB_COUL = 11;
  localparam int QB_SEQ = 12;
  localparam int QB_CAUT = 14;
  localparam int OB_CAL = 0;
  localparam int OB_TRIG = 5;
  localparam int OB_ARM = 6;
  localparam int OB_CALC = 9;
  localparam int OB_IDLE = 10;
  localparam int OB_SEQ = 11;
  localparam int TB_WAIT = 1;
  localparam int AB_WAIT = 1;
  localparam int SB_GATE1 = 1;
  localparam int SB_GATE2 = 2;
  localparam logic [NGRP-1:0][DW-1:0] USED_MASK = {16'h0006, 16'h0002, 16'h0002, 16'h0e61, 16'h5f13};
  localparam logic [DW-1:0] RISE_RST = 16'hffff;
  localparam logic [DW-1:0] FALL_RST = 16'h0000;
  localparam logic [SW-1:0] SEL_NREG = 4'ha;
  localparam int SEL_FALL_BIT = 0;
endpackage : tsf_pkg

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top import tsf_pkg::*;;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [16:0] c = 17'h00001;
  logic CMD_WR = 1'b0;
  logic [SW-1:0] CMD_SEL = 4'h0;
  logic [DW-1:0] CMD_DATA = 16'h0000;
  logic [SW-1:0] QRY_SEL = 4'h0;
  logic [DW-1:0] QRY_DATA;
  logic EVT_RD = 1'b0;
  logic [GW-1:0] EVT_SEL = 3'h0;
  logic [DW-1:0] EVT_DATA;
  logic EVT_CLR_ALL = 1'b0;
  logic [NGRP-1:0] EVT_PENDING;
  logic SEL_ERROR;
  logic last_err;
  logic [15:0] d;
  logic [15:0] e;
  logic [31:0] r;
  int idx;
  int g;
  int bad_count = 0;
  int checked = 0;
  // input index, group, expected event word
  logic [31:0] rows [19] = '{32'h00000001, 32'h01000002, 32'h02000010, 32'h03000200, 32'h04000400,
    32'h05000800, 32'h06001000, 32'h07004000, 32'h08000100, 32'h09010001, 32'h0a010020, 32'h0b010040,
    32'h0c010200, 32'h0d010400, 32'h0e010800, 32'h0a020002, 32'h0b030002, 32'h0f040002, 32'h10040004};

  always #2.5 CLK = ~CLK;

  tsf_top tsf_top_i (.CLK(CLK), .RESET(RESET), .INVALID_VOLTS(c[0]), .INVALID_AMPS(c[1]),
    .INVALID_TEMP(c[2]), .INVALID_HUMIDITY(c[3]), .INVALID_OHMS(c[4]), .INVALID_COULOMBS(c[5]),
    .SEQ_TEST_ABORTED(c[6]), .COMMAND_CAUTION(c[7]), .ADJUST_PROC_SUMMARY(c[8]), .CAL_START(c[9]),
    .TRIG_LAYER_WAIT(c[10]), .ARM_LAYER_WAIT(c[11]), .READING_COMPUTE_BUSY(c[12]),
    .IDLE_ENTERED(c[13]), .SEQ_TEST_RUNNING(c[14]), .ARM_LAYER_ONE(c[15]), .ARM_LAYER_TWO(c[16]),
    .CMD_WR(CMD_WR), .CMD_SEL(CMD_SEL), .CMD_DATA(CMD_DATA), .QRY_SEL(QRY_SEL), .QRY_DATA(QRY_DATA),
    .EVT_RD(EVT_RD), .EVT_SEL(EVT_SEL), .EVT_DATA(EVT_DATA), .EVT_CLR_ALL(EVT_CLR_ALL),
    .EVT_PENDING(EVT_PENDING), .SEL_ERROR(SEL_ERROR));

  task tick;
    @(posedge CLK);
    #1;
  endtask : tick

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // strobe drops with a spare edge so back-to-back calls never reassign in one step
  task wr(input logic [3:0] s, input logic [15:0] v);
    CMD_SEL = s;
    CMD_DATA = v;
    CMD_WR = 1'b1;
    tick;
    CMD_WR = 1'b0;
    last_err = SEL_ERROR;
    tick;
  endtask : wr

  task qry(input logic [3:0] s, output logic [15:0] v);
    QRY_SEL = s;
    tick;
    v = QRY_DATA;
  endtask : qry

  task evrd(input logic [2:0] s, output logic [15:0] v);
    EVT_SEL = s;
    EVT_RD = 1'b1;
    tick;
    v = EVT_DATA;
    EVT_RD = 1'b0;
    last_err = SEL_ERROR;
    tick;
  endtask : evrd

  task results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  initial begin
    #(5 * 4000);
    bad_count++;
    results;
  end

  initial begin
    repeat (12) tick;
    RESET = 1'b0;
    repeat (3) tick;
    // a level already high at reset is no edge
    check("pending_rst", {11'h000, EVT_PENDING}, 16'h0000);
    for (int s = 0; s < 10; s++) begin
      qry(s[3:0], d);
      check("filter_rst", d, s[0] ? 16'h0000 : USED_MASK[s >> 1]);
    end
    c[0] = 1'b0;
    repeat (3) tick;
    check("pending_nofall", {11'h000, EVT_PENDING}, 16'h0000);
    for (int s = 0; s < 10; s++) begin
      wr(s[3:0], 16'hffff);
      qry(s[3:0], d);
      check("wr_mask", d, USED_MASK[s >> 1]);
    end
    for (int i = 0; i < 19; i++) begin
      r = rows[i];
      idx = r[31:24];
      g = r[23:16];
      e = r[15:0];
      c[idx] = 1'b1;
      repeat (3) tick;
      check("pending_rise", {15'h0000, EVT_PENDING[g]}, 16'h0001);
      evrd(g[2:0], d);
      check("rise_evt", d, e);
      c[idx] = 1'b0;
      repeat (3) tick;
      evrd(g[2:0], d);
      check("fall_evt", d, e);
      EVT_CLR_ALL = 1'b1;
      tick;
      EVT_CLR_ALL = 1'b0;
      tick;
      check("pending_clr", {11'h000, EVT_PENDING}, 16'h0000);
    end
    wr(4'h0, 16'h0001);
    c[1:0] = 2'b11;
    repeat (8) tick;
    check("pending_hold", {15'h0000, EVT_PENDING[0]}, 16'h0001);
    evrd(3'h0, d);
    check("rise_gated", d, 16'h0001);
    evrd(3'h0, d);
    check("read_clears", d, 16'h0000);
    wr(4'h1, 16'h0000);
    qry(4'h1, d);
    check("fall_zero", d, 16'h0000);
    c[1:0] = 2'b00;
    repeat (3) tick;
    check("pending_off", {15'h0000, EVT_PENDING[0]}, 16'h0000);
    // set beats read clear in one cycle
    c[0] = 1'b1;
    evrd(3'h0, d);
    check("set_rd", d, 16'h0000);
    check("set_pend", {15'h0000, EVT_PENDING[0]}, 16'h0001);
    // disabled rise, enabled fall on one bit
    wr(4'h2, 16'h0a61);
    check("wr_ok", {15'h0000, last_err}, 16'h0000);
    c[13] = 1'b1;
    repeat (3) tick;
    check("idle_norise", {15'h0000, EVT_PENDING[1]}, 16'h0000);
    c[13] = 1'b0;
    repeat (3) tick;
    evrd(3'h1, d);
    check("idle_fall", d, 16'h0400);
    wr(4'ha, 16'h1234);
    check("wr_err", {15'h0000, last_err}, 16'h0001);
    qry(4'ha, d);
    check("qry_bad", d, 16'h0000);
    evrd(3'h5, d);
    check("evt_bad", d, 16'h0000);
    check("evt_err", {15'h0000, last_err}, 16'h0001);
    wr(4'h8, 16'hffff);
    qry(4'h8, d);
    check("seq_rise_mask", d, 16'h0006);
    // second reset in mid-run restores filters
    RESET = 1'b1;
    tick;
    RESET = 1'b0;
    tick;
    qry(4'h0, d);
    check("rise_rst2", d, USED_MASK[0]);
    qry(4'h3, d);
    check("fall_rst2", d, 16'h0000);
    results;
  end
endmodule : tb_top
